// ---- rtl/host_regs_defines.svh ----
// Offsets, field positions, reset values and timing counts of the host command/status bank.
// Overview of operation
// - Capability word upper half holds BCD version
// - Capability low byte reads length 0x10
// - Structural word reports one downstream port
// - Park and programmable list flags read one
// - Threshold field, default 08h, sets high-speed interrupt interval
// - Park enable bit 11, default one
// - Park count field limits successive transactions
// - Doorbell raises advance flag after schedule advances
// - Async enable gates async schedule fetch
// - Periodic enable gates periodic schedule fetch
// - Frame list size select, default 1024
// - Soft reset bit resets command fields and pulses host_soft_reset
// - Run/stop bit runs schedules, resets zero
// - Halted clear while running, set when stopped
// - Schedule state bits report actual running state
// - Reclamation bit reports empty async schedule
// - System bus error sets system error flag
// - Frame index wrap sets rollover flag
// - Port change rise sets port change flag
// - Completion sets done; error completion sets error
// - Done, error, advance interrupt at threshold boundary
// - System error, rollover, port change interrupt immediately
// - Flags clear only by writing one
`ifndef HOST_REGS_DEFINES_SVH
`define HOST_REGS_DEFINES_SVH

`define OFS_CAPABILITY      12'h000
`define OFS_STRUCTURE       12'h004
`define OFS_CAP_PARAMS      12'h008
`define OFS_COMMAND         12'h010
`define OFS_STATUS          12'h014
`define OFS_IRQ_ENABLE      12'h018

`define CAPABILITY_LENGTH   8'h10
`define N_DOWNSTREAM_PORTS  4'h1

`define CMD_RUN             0
`define CMD_SOFT_RESET      1
`define CMD_LIST_SIZE_LO    2
`define CMD_PERIODIC_EN     4
`define CMD_ASYNC_EN        5
`define CMD_DOORBELL        6
`define CMD_PARK_CNT_LO     8
`define CMD_PARK_EN         11
`define CMD_THRESH_LO       16

`define STS_DONE            0
`define STS_XFER_ERR        1
`define STS_PORT_CHG        2
`define STS_ROLLOVER        3
`define STS_SYS_ERR         4
`define STS_ADVANCE         5
`define STS_HALTED          12
`define STS_RECLAIM         13
`define STS_PERIODIC        14
`define STS_ASYNC           15

`define RST_THRESHOLD       8'h08
`define RST_PARK_CNT        2'h3
`define MICROFRAME_NS       125000
`define CLK_PERIOD_NS       8
`define MICROFRAME_CYCLES   (`MICROFRAME_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/host_regs_pkg.sv ----
// Types shared by the host command/status bank.
package host_regs_pkg;
    typedef logic [5:0]  irq_bits_t;
    typedef logic [1:0]  list_size_t;
    typedef enum logic [2:0] {
        HC_HALTED   = 3'b001,
        HC_RUNNING  = 3'b010,
        HC_STOPPING = 3'b100
    } run_state_t;
endpackage : host_regs_pkg

// ---- rtl/usb_host_cmd_status_regs.sv ----
// Capability, command, status and interrupt-enable registers of the host controller.
`timescale 1ns/1ps
`include "host_regs_defines.svh"
module usb_host_cmd_status_regs #(
    parameter int unsigned MICROFRAME_LEN = `MICROFRAME_CYCLES,
    parameter logic [15:0] VERSION_BCD    = 16'h0000
)(
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // Register port.
    input  wire logic [11:0]               reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    // Schedule engine controls.
    output logic                           run_stop,
    output logic                           host_soft_reset,
    output logic                           async_sched_enable,
    output logic                           periodic_sched_enable,
    output logic                           park_enable,
    output logic      [1:0]                park_count,
    output host_regs_pkg::list_size_t      frame_list_size_sel,
    output logic                           advance_doorbell,
    // Schedule engine status.
    input  wire logic                      engine_idle,
    input  wire logic                      async_active,
    input  wire logic                      periodic_active,
    input  wire logic                      reclamation,
    input  wire logic                      async_advanced,
    // Engine events, one-cycle pulses; high_speed is a level.
    input  wire logic                      xfer_done,
    input  wire logic                      xfer_error,
    input  wire logic                      sys_bus_error,
    input  wire logic                      index_wrap,
    input  wire logic                      port_change_bits,
    input  wire logic                      high_speed,
    // Interrupt.
    output logic                           host_irq
);
    import host_regs_pkg::*;

    logic        rst_sync1_r;
    logic        rst_n_r;
    logic [7:0]  threshold_r;
    logic        run_r;
    logic        soft_rst_r;
    logic        async_en_r;
    logic        periodic_en_r;
    logic        doorbell_r;
    logic        park_en_r;
    logic [1:0]  park_cnt_r;
    list_size_t  list_size_r;
    irq_bits_t   flags_r;
    irq_bits_t   flags_nxt;
    irq_bits_t   irq_en_r;
    run_state_t  state_r;
    logic        port_chg_d_r;
    logic [16:0] ufr_cnt_r;
    logic [6:0]  ufr_num_r;
    logic        boundary;
    logic        thresh_pending_r;
    logic [31:0] cmd_word;
    logic [31:0] sts_word;
    logic        wr_cmd;
    logic        wr_sts;
    logic        wr_ien;

    // Reset release through two flip-flops.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync1_r <= 1'b0;
            rst_n_r     <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_n_r     <= rst_sync1_r;
        end
    end

    assign wr_cmd = reg_wr && (reg_addr == `OFS_COMMAND);
    assign wr_sts = reg_wr && (reg_addr == `OFS_STATUS);
    assign wr_ien = reg_wr && (reg_addr == `OFS_IRQ_ENABLE);

    // Command register; soft reset returns its fields to defaults.
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            threshold_r   <= `RST_THRESHOLD;
            park_en_r     <= 1'b1;
            park_cnt_r    <= `RST_PARK_CNT;
            async_en_r    <= 1'b0;
            periodic_en_r <= 1'b0;
            list_size_r   <= 2'h0;
            run_r         <= 1'b0;
            soft_rst_r    <= 1'b0;
        end
        else if (soft_rst_r)
        begin
            threshold_r   <= `RST_THRESHOLD;
            park_en_r     <= 1'b1;
            park_cnt_r    <= `RST_PARK_CNT;
            async_en_r    <= 1'b0;
            periodic_en_r <= 1'b0;
            list_size_r   <= 2'h0;
            run_r         <= 1'b0;
            soft_rst_r    <= 1'b0;
        end
        else if (wr_cmd)
        begin
            threshold_r   <= reg_wdata[`CMD_THRESH_LO +: 8];
            park_en_r     <= reg_wdata[`CMD_PARK_EN];
            park_cnt_r    <= reg_wdata[`CMD_PARK_CNT_LO +: 2];
            async_en_r    <= reg_wdata[`CMD_ASYNC_EN];
            periodic_en_r <= reg_wdata[`CMD_PERIODIC_EN];
            list_size_r   <= reg_wdata[`CMD_LIST_SIZE_LO +: 2];
            run_r         <= reg_wdata[`CMD_RUN];
            soft_rst_r    <= reg_wdata[`CMD_SOFT_RESET];
        end
    end

    // Doorbell holds until the engine reports the advance.
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            doorbell_r <= 1'b0;
        else if (soft_rst_r || async_advanced)
            doorbell_r <= 1'b0;
        else if (wr_cmd && reg_wdata[`CMD_DOORBELL])
            doorbell_r <= 1'b1;
    end

    // Run state: halted drops the cycle after run is set, rises only once the engine is idle.
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            state_r <= HC_HALTED;
        else
        begin
            case (state_r)
                HC_HALTED:   if (run_r) state_r <= HC_RUNNING;
                HC_RUNNING:  if (!run_r) state_r <= HC_STOPPING;
                HC_STOPPING: if (run_r) state_r <= HC_RUNNING;
                             else if (engine_idle) state_r <= HC_HALTED;
                default:     state_r <= HC_HALTED;
            endcase
        end
    end

    // Microframe counter producing threshold boundaries.
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ufr_cnt_r <= 17'h0_0000;
            ufr_num_r <= 7'h00;
        end
        else if (ufr_cnt_r == 17'(MICROFRAME_LEN - 1))
        begin
            ufr_cnt_r <= 17'h0_0000;
            ufr_num_r <= ufr_num_r + 7'h01;
        end
        else
            ufr_cnt_r <= ufr_cnt_r + 17'h0_0001;
    end

    // Full speed or a zero threshold value falls back to every microframe.
    always_comb
    begin
        boundary = 1'b0;
        if (ufr_cnt_r == 17'(MICROFRAME_LEN - 1))
        begin
            if (!high_speed || threshold_r == 8'h00)
                boundary = 1'b1;
            else
                boundary = ((ufr_num_r + 7'h01) & (threshold_r[6:0] - 7'h01)) == 7'h00;
        end
    end

    // Sticky flags: hardware set wins over a write-one clear.
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_sts)
            flags_nxt = flags_r & ~reg_wdata[5:0];
        if (xfer_done)
            flags_nxt[`STS_DONE] = 1'b1;
        if (xfer_error)
            flags_nxt[`STS_XFER_ERR] = 1'b1;
        if (port_change_bits && !port_chg_d_r)
            flags_nxt[`STS_PORT_CHG] = 1'b1;
        if (index_wrap)
            flags_nxt[`STS_ROLLOVER] = 1'b1;
        if (sys_bus_error)
            flags_nxt[`STS_SYS_ERR] = 1'b1;
        if (async_advanced && doorbell_r)
            flags_nxt[`STS_ADVANCE] = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            flags_r      <= 6'h00;
            port_chg_d_r <= 1'b0;
        end
        else
        begin
            flags_r      <= flags_nxt;
            port_chg_d_r <= port_change_bits;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            irq_en_r <= 6'h00;
        else if (wr_ien)
            irq_en_r <= reg_wdata[5:0];
    end

    // Threshold-gated sources become visible only at a boundary.
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            thresh_pending_r <= 1'b0;
        else if (boundary)
            thresh_pending_r <= |(flags_r & irq_en_r & 6'h23);
        else if (!(|(flags_r & irq_en_r & 6'h23)))
            thresh_pending_r <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            host_irq <= 1'b0;
        else
            host_irq <= (|(flags_r & irq_en_r & 6'h1C))
                        || thresh_pending_r;
    end

    assign cmd_word = {8'h00, threshold_r, 4'h0, park_en_r, 1'b0, park_cnt_r, 1'b0,
                       doorbell_r, async_en_r, periodic_en_r, list_size_r, soft_rst_r,
                       run_r};
    assign sts_word = {16'h0000, async_active, periodic_active, reclamation,
                       state_r == HC_HALTED, 6'h00, flags_r};

    // Read data one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `OFS_CAPABILITY: reg_rdata <= {VERSION_BCD, 8'h00, `CAPABILITY_LENGTH};
                `OFS_STRUCTURE:  reg_rdata <= {28'h000_0000, `N_DOWNSTREAM_PORTS};
                `OFS_CAP_PARAMS: reg_rdata <= 32'h0000_0006;
                `OFS_COMMAND:    reg_rdata <= cmd_word;
                `OFS_STATUS:     reg_rdata <= sts_word;
                `OFS_IRQ_ENABLE: reg_rdata <= {26'h000_0000, irq_en_r};
                default:         reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    assign run_stop              = state_r != HC_HALTED && run_r;
    assign host_soft_reset       = soft_rst_r;
    assign async_sched_enable    = async_en_r;
    assign periodic_sched_enable = periodic_en_r;
    assign park_enable           = park_en_r;
    assign park_count            = park_cnt_r;
    assign frame_list_size_sel   = list_size_r;
    assign advance_doorbell      = doorbell_r;

    a_halt_while_run: assert property (@(posedge clk) disable iff (!rst_n_r)
        $rose(run_r) |=> !sts_word[`STS_HALTED]) else $error("halted while run set");
    a_halt_waits_idle: assert property (@(posedge clk) disable iff (!rst_n_r)
        (state_r == HC_STOPPING && !engine_idle) |=> !sts_word[`STS_HALTED])
        else $error("halted before idle");
    a_sys_err_sets: assert property (@(posedge clk) disable iff (!rst_n_r)
        sys_bus_error |=> flags_r[`STS_SYS_ERR]) else $error("system error lost");
    a_rollover_sets: assert property (@(posedge clk) disable iff (!rst_n_r)
        index_wrap |=> flags_r[`STS_ROLLOVER]) else $error("rollover lost");
    a_done_sets: assert property (@(posedge clk) disable iff (!rst_n_r)
        xfer_done |=> flags_r[`STS_DONE]) else $error("done lost");
    a_err_sets: assert property (@(posedge clk) disable iff (!rst_n_r)
        xfer_error |=> flags_r[`STS_XFER_ERR]) else $error("transfer error lost");
    a_w1c_zero_kept: assert property (@(posedge clk) disable iff (!rst_n_r)
        (wr_sts && !xfer_done && !xfer_error && !index_wrap && !sys_bus_error
         && !async_advanced && !port_change_bits)
        |=> flags_r == ($past(flags_r) & ~$past(reg_wdata[5:0])))
        else $error("zero write changed flag");
    a_imm_irq: assert property (@(posedge clk) disable iff (!rst_n_r)
        |(flags_r & irq_en_r & 6'h1C) |=> host_irq) else $error("immediate irq missing");
    a_irq_release: assert property (@(posedge clk) disable iff (!rst_n_r)
        (!(|(flags_r & irq_en_r)) && !thresh_pending_r) |=> !host_irq)
        else $error("irq without flag");
    a_cap_length: assert property (@(posedge clk) disable iff (!rst_n_r)
        (reg_rd && reg_addr == `OFS_CAPABILITY) |=> reg_rdata[7:0] == 8'h10)
        else $error("bad capability length");
endmodule : usb_host_cmd_status_regs

// ---- tb/sched_engine_model.sv ----
// Behavioural schedule engine facing the host command/status bank.
`timescale 1ns/1ps
module sched_engine_model #(
    parameter int LAG = 3
)(
    // Clock, reset and controls from the bank.
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic run_stop,
    input  wire logic async_en,
    input  wire logic periodic_en,
    input  wire logic doorbell,
    // Engine state and events back to the bank.
    output logic      engine_idle,
    output logic      async_active,
    output logic      periodic_active,
    output logic      reclamation,
    output logic      async_advanced
);
    logic [LAG-1:0] run_sr;
    logic [LAG-1:0] asy_sr;
    logic [LAG-1:0] per_sr;
    logic [3:0]     bell_cnt;

    // Schedule states trail the enables by LAG cycles, as a real engine would.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_sr         <= '0;
            asy_sr         <= '0;
            per_sr         <= '0;
            bell_cnt       <= 4'h0;
            async_advanced <= 1'b0;
        end
        else
        begin
            run_sr         <= {run_sr[LAG-2:0], run_stop};
            asy_sr         <= {asy_sr[LAG-2:0], run_stop & async_en};
            per_sr         <= {per_sr[LAG-2:0], run_stop & periodic_en};
            bell_cnt       <= (doorbell && !async_advanced) ? bell_cnt + 4'h1 : 4'h0;
            async_advanced <= bell_cnt == 4'h4;
        end
    end

    assign engine_idle     = !run_sr[LAG-1];
    assign async_active    = asy_sr[LAG-1];
    assign periodic_active = per_sr[LAG-1];
    assign reclamation     = asy_sr[LAG-1];
endmodule : sched_engine_model

// ---- tb/test_usb_host_cmd_status_regs.sv ----
// Self-checking bench for the host command/status bank.
`timescale 1ns/1ps
`include "host_regs_defines.svh"
module test_usb_host_cmd_status_regs;
    import host_regs_pkg::*;
    localparam int          MFL = 20;
    localparam logic [15:0] VER = 16'h0042; // Arbitrary revision value.
    logic        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rd_q = 0, high_speed = 1;
    logic [11:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rv, e, exp_q[$];
    logic [4:0]  ev = '0;
    logic [1:0]  park_count;
    list_size_t  frame_list_size_sel;
    logic        run_stop, host_soft_reset, async_sched_enable, periodic_sched_enable;
    logic        park_enable, advance_doorbell, host_irq, engine_idle, async_active;
    logic        periodic_active, reclamation, async_advanced;
    logic        xfer_done, xfer_error, sys_bus_error, index_wrap, port_change_bits;
    int          bad_count = 0, n_tests = 0, cycles = 0, seed = 69453;

    assign {sys_bus_error, index_wrap, port_change_bits, xfer_error, xfer_done} = ev;

    usb_host_cmd_status_regs #(.MICROFRAME_LEN(MFL), .VERSION_BCD(VER)) dut (
        .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .run_stop, .host_soft_reset, .async_sched_enable, .periodic_sched_enable,
        .park_enable, .park_count, .frame_list_size_sel, .advance_doorbell,
        .engine_idle, .async_active, .periodic_active, .reclamation, .async_advanced,
        .xfer_done, .xfer_error, .sys_bus_error, .index_wrap, .port_change_bits,
        .high_speed, .host_irq);

    sched_engine_model engine (
        .clk, .rstn, .run_stop, .async_en(async_sched_enable),
        .periodic_en(periodic_sched_enable), .doorbell(advance_doorbell),
        .engine_idle, .async_active, .periodic_active, .reclamation, .async_advanced);

    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ex);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(ex);
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 5'(1 << k);
        @(posedge clk);
        ev <= '0;
    endtask : pulse

    task automatic wait_irq(input int n);
        for (int i = 0; i < n && host_irq !== 1'b1; i++)
            @(posedge clk);
        #1;
    endtask : wait_irq

    // Read data stand only in the cycle after the strobe; the oldest note is compared then.
    always @(posedge clk)
    begin
        if (rd_q)
            chk("read data", exp_q.pop_front(), reg_rdata);
        rd_q <= reg_rd;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        wt(3);
        rd(`OFS_CAPABILITY, {VER, 16'h0010});
        rd(`OFS_STRUCTURE, 32'h0000_0001);
        rd(`OFS_CAP_PARAMS, 32'h0000_0006);
        rd(`OFS_COMMAND, 32'h0008_0B00);
        rd(`OFS_STATUS, 32'h0000_1000);
        rd(`OFS_IRQ_ENABLE, 32'h0000_0000);
        rd(12'h01C, 32'h0000_0000);
        rv = $random(seed);
        wr(`OFS_CAP_PARAMS, rv);
        rd(`OFS_CAP_PARAMS, 32'h0000_0006);
        wr(`OFS_IRQ_ENABLE, rv);
        rd(`OFS_IRQ_ENABLE, rv & 32'h0000_003F);
        $display("test reset values done");
        for (int k = 0; k < 5; k++)
        begin
            e = 32'h0000_1000 | (32'h1 << k);
            wr(`OFS_IRQ_ENABLE, 32'h0);
            pulse(k);
            wt(3);
            chk("masked irq", 1'b0, host_irq);
            rd(`OFS_STATUS, e);
            wr(`OFS_IRQ_ENABLE, 32'h1 << k);
            wait_irq(k < 2 ? 8 * MFL + 8 : 3);
            chk("irq", 1'b1, host_irq);
            wr(`OFS_STATUS, ~(32'h1 << k));
            rd(`OFS_STATUS, e);
            wr(`OFS_STATUS, 32'h1 << k);
            wt(2);
            chk("irq release", 1'b0, host_irq);
        end
        // At full speed the threshold is ignored and every microframe end is a boundary.
        high_speed <= 1'b0;
        wr(`OFS_IRQ_ENABLE, 32'h0000_0001);
        pulse(0);
        wait_irq(MFL + 4);
        chk("full speed irq", 1'b1, host_irq);
        wr(`OFS_STATUS, 32'h0000_0001);
        high_speed <= 1'b1;
        wt(2);
        chk("full speed release", 1'b0, host_irq);
        $display("test event flags done");
        for (int v = 0; v < 4; v++)
        begin
            e = 32'h0008_0000 | (v << 8) | (v << 2) | (v[0] << 11);
            wr(`OFS_COMMAND, e | 32'hFF00_F480);
            chk("list size", v, frame_list_size_sel);
            chk("park count", v, park_count);
            chk("park enable", v & 1, park_enable);
            rd(`OFS_COMMAND, e);
        end
        $display("test command fields done");
        wr(`OFS_COMMAND, 32'h0008_0B31);
        // Run reaches the engine one cycle later, once the halt state has been left.
        wt(1);
        chk("run", 1'b1, run_stop);
        chk("enables", 2'b11, {async_sched_enable, periodic_sched_enable});
        wt(6);
        rd(`OFS_STATUS, 32'h0000_E000);
        wr(`OFS_COMMAND, 32'h0008_0B71);
        chk("doorbell", 1'b1, advance_doorbell);
        wt(12);
        chk("doorbell served", 1'b0, advance_doorbell);
        rd(`OFS_STATUS, 32'h0000_E020);
        wr(`OFS_STATUS, 32'h0000_0020);
        wr(`OFS_COMMAND, 32'h0008_0B00);
        wt(8);
        chk("stopped", 1'b0, run_stop);
        rd(`OFS_STATUS, 32'h0000_1000);
        $display("test run and stop done");
        wr(`OFS_COMMAND, 32'h0000_0032);
        chk("soft reset", 1'b1, host_soft_reset);
        wt(1);
        chk("soft reset end", 1'b0, host_soft_reset);
        rd(`OFS_COMMAND, 32'h0008_0B00);
        wt(4);
        $display("test soft reset done");
        give_verdict();
    end
endmodule : test_usb_host_cmd_status_regs
